// file: src/rwd_pkg.sv
// Constants shared by the reset and wake distribution block
package rwd_pkg;
  localparam int NUM_SRC = 11;
  // Reset source indices
  localparam int SRC_POR    = 0;
  localparam int SRC_LVR    = 1;
  localparam int SRC_PIN    = 2;
  localparam int SRC_WATCHDOG_RESET   = 3;
  localparam int SRC_CLKLS  = 4;
  localparam int SRC_LCKLS  = 5;
  localparam int SRC_STPERR = 6;
  localparam int SRC_SOFT   = 7;
  localparam int SRC_LOCKUP = 8;
  localparam int SRC_DBGPRT = 9;
  localparam int SRC_DEBUG  = 10;
  // Module reset output indices
  localparam int NUM_MOD    = 8;
  localparam int MOD_PWR    = 0;
  localparam int MOD_SYSINT = 1;
  localparam int MOD_MODE   = 2;
  localparam int MOD_RSTCTL = 3;
  localparam int MOD_WATCHDOG_RESET   = 4;
  localparam int MOD_CLKGEN = 5;
  localparam int MOD_LOW_POWER_TIMER  = 6;
  localparam int MOD_OTHER  = 7;
  localparam int SYNC_STAGES = 2;
  localparam logic [NUM_SRC-1:0] CAUSE_RST = 11'h001;
  typedef enum logic [2:0] {RWD_RUN, RWD_WAIT, RWD_VERY_LOW_POWER_WAIT, RWD_PSTOP, RWD_STOP, RWD_VERY_LOW_POWER_STOP} rwd_mode_t;
endpackage

// file: src/rwd_rst_sync.sv
// Reset stretcher: asynchronous assert, synchronous release
`timescale 1ns/1ps
module rwd_rst_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clk,
  input  wire logic rst_req,
  output logic      rst_out
);
  logic [STAGES-1:0] chain;
  always_ff @(posedge clk or posedge rst_req) begin
    if (rst_req) begin
      chain <= '1;
    end else begin
      chain <= {chain[STAGES-2:0], 1'b0};
    end
  end
  assign rst_out = chain[STAGES-1];
endmodule

// file: src/rwd_top.sv
// Reset distribution and deep-sleep wake detection
`timescale 1ns/1ps
module rwd_top #(
  parameter int NUM_PIN  = 8,
  parameter int NUM_PERI = 8
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         clk_en,
  input  wire logic                         power_on_reset,
  input  wire logic                         low_voltage_reset,
  input  wire logic                         pin_reset,
  input  wire logic                         watchdog_reset,
  input  wire logic                         clock_loss_reset,
  input  wire logic                         lock_loss_reset,
  input  wire logic                         stop_ack_error_reset,
  input  wire logic                         software_reset,
  input  wire logic                         lockup_reset,
  input  wire logic                         debug_port_reset_request,
  input  wire logic                         debug_reset,
  input  wire rwd_pkg::rwd_mode_t           power_mode,
  input  wire logic [NUM_PIN-1:0]           pin_irq,
  input  wire logic [NUM_PIN-1:0]           pin_irq_en,
  input  wire logic [NUM_PERI-1:0]          peri_wake,
  input  wire logic                         clkgen_wake,
  input  wire logic                         clkgen_on_slow_internal_ref_clock,
  input  wire logic                         nmi_req,
  input  wire logic                         irq_ack,
  output logic [rwd_pkg::NUM_MOD-1:0]       module_rst,
  output logic                              clock_resume_req,
  output logic                              wake_irq_pending,
  output logic [rwd_pkg::NUM_SRC-1:0]       reset_cause
);
  wire [rwd_pkg::NUM_SRC-1:0] src = {debug_reset, debug_port_reset_request, lockup_reset,
                                     software_reset, stop_ack_error_reset, lock_loss_reset,
                                     clock_loss_reset, watchdog_reset, pin_reset,
                                     low_voltage_reset, power_on_reset};
  wire power_rst  = src[rwd_pkg::SRC_POR] | src[rwd_pkg::SRC_LVR];
  wire system_rst = |src[rwd_pkg::SRC_DEBUG:rwd_pkg::SRC_PIN];
  wire any_rst    = power_rst | system_rst | sys_rst;
  // Timer keeps running through system resets; only power resets and sys_rst reset it
  wire [rwd_pkg::NUM_MOD-1:0] mod_req;
  genvar g;
  generate
    for (g = 0; g < rwd_pkg::NUM_MOD; g++) begin : g_map
      if (g == rwd_pkg::MOD_LOW_POWER_TIMER) begin : g_tmr
        assign mod_req[g] = power_rst | sys_rst;
      end else begin : g_all
        assign mod_req[g] = any_rst;
      end
      rwd_rst_sync #(.STAGES(rwd_pkg::SYNC_STAGES)) u_sync (
        .clk     (clk),
        .rst_req (mod_req[g]),
        .rst_out (module_rst[g])
      );
    end
  endgenerate

  // Priority encoder for cause: lowest index wins
  logic [rwd_pkg::NUM_SRC-1:0] cause_onehot;
  always_comb begin
    cause_onehot = '0;
    for (int i = rwd_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (src[i]) begin
        cause_onehot = '0;
        cause_onehot[i] = 1'b1;
      end
    end
  end
  // Cause register lives in the always-on domain, reset to CAUSE_RST only by sys_rst
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_cause <= rwd_pkg::CAUSE_RST;
    end else if (clk_en && (power_rst || system_rst)) begin
      reset_cause <= cause_onehot;
    end
  end

  // Wake detection
  wire deep_sleep = (power_mode == rwd_pkg::RWD_PSTOP) || (power_mode == rwd_pkg::RWD_STOP) ||
                    (power_mode == rwd_pkg::RWD_VERY_LOW_POWER_STOP);
  wire wait_mode  = (power_mode == rwd_pkg::RWD_WAIT) || (power_mode == rwd_pkg::RWD_VERY_LOW_POWER_WAIT);
  wire pin_wake   = |(pin_irq & pin_irq_en);
  wire clkg_wake  = clkgen_wake && clkgen_on_slow_internal_ref_clock && (power_mode == rwd_pkg::RWD_STOP);
  wire rst_wake   = pin_reset | watchdog_reset | clock_loss_reset | lock_loss_reset;
  wire wake_evt   = pin_wake | clkg_wake | nmi_req | (|peri_wake) | rst_wake;
  // Synchronous capture: event is registered on the clock edge, with clk_en high, in deep sleep
  wire wake_async = deep_sleep && wake_evt;
  logic wake_seen;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_seen <= 1'b0;
    end else if (clk_en) begin
      wake_seen <= wake_async || (wake_seen && deep_sleep);
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_resume_req <= 1'b0;
    end else if (clk_en) begin
      clock_resume_req <= wake_async || (wake_seen && deep_sleep);
    end
  end
  // Pending stays until interrupt controller takes it; set wins over ack
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_irq_pending <= 1'b0;
    end else if (clk_en) begin
      wake_irq_pending <= wake_seen || (wake_irq_pending && !irq_ack);
    end
  end

  // Reset mapping checks
  sequence s_tmr_free;
    !module_rst[rwd_pkg::MOD_LOW_POWER_TIMER] && !power_rst;
  endsequence
  sequence s_sys_only;
    system_rst && !power_rst;
  endsequence

  a_timer_kept: assert property (@(posedge clk) disable iff (sys_rst)
    s_tmr_free ##1 s_sys_only
    |-> !module_rst[rwd_pkg::MOD_LOW_POWER_TIMER])
    else $error("timer reset by system reset");

  a_power_all: assert property (@(posedge clk) disable iff (sys_rst)
    power_rst
    |-> &module_rst)
    else $error("power reset missed a module");

  a_sys_map: assert property (@(posedge clk) disable iff (sys_rst)
    system_rst
    |-> (&module_rst[rwd_pkg::MOD_CLKGEN:rwd_pkg::MOD_PWR]) && module_rst[rwd_pkg::MOD_OTHER])
    else $error("system reset missed a module");

  a_sys_others: assert property (@(posedge clk) disable iff (sys_rst)
    (lockup_reset || debug_port_reset_request)
    |-> module_rst[rwd_pkg::MOD_OTHER])
    else $error("system reset not applied");

  a_rel_early: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(any_rst)
    |-> module_rst[rwd_pkg::MOD_OTHER])
    else $error("module reset released too early");

  a_rel_sync: assert property (@(posedge clk) disable iff (sys_rst)
    (!any_rst) [*3]
    |-> module_rst == '0)
    else $error("module reset not released");

  // Wake detection checks
  sequence s_wake_in_sleep;
    clk_en && deep_sleep && nmi_req;
  endsequence
  sequence s_deep_evt;
    clk_en && deep_sleep && wake_evt;
  endsequence

  a_wake_resume: assert property (@(posedge clk) disable iff (sys_rst)
    s_deep_evt
    |=> clock_resume_req)
    else $error("no clock resume on deep sleep wake");

  a_nmi_resume: assert property (@(posedge clk) disable iff (sys_rst)
    s_wake_in_sleep
    |=> clock_resume_req)
    else $error("no clock resume on nmi");

  a_pin_wake: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && deep_sleep && pin_wake
    |=> clock_resume_req)
    else $error("enabled pin interrupt did not wake");

  a_rst_wake: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && deep_sleep && rst_wake
    |=> clock_resume_req)
    else $error("reset source did not end deep sleep");

  a_clkg_wake: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && clkg_wake
    |=> clock_resume_req)
    else $error("clock generator wake lost");

  a_clkg_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && clkgen_wake && !clkgen_on_slow_internal_ref_clock && !wake_seen && (power_mode == rwd_pkg::RWD_STOP)
     && !nmi_req && !pin_wake && !(|peri_wake) && !rst_wake)
    |=> !clock_resume_req)
    else $error("clock generator woke off slow clock");

  a_pend_hold: assert property (@(posedge clk) disable iff (sys_rst)
    s_wake_in_sleep ##1 clk_en ##1 (clk_en && !irq_ack)
    |=> wake_irq_pending)
    else $error("wake not pending");

  a_pend_ack: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !wake_seen && irq_ack
    |=> !wake_irq_pending)
    else $error("pending wake not cleared by take");

  a_wait_nodet: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && !deep_sleep && !wake_seen)
    |=> !clock_resume_req)
    else $error("detector active outside deep sleep");

  a_wait_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && wait_mode && !wake_seen
    |=> !clock_resume_req)
    else $error("detector woke from a wait mode");

  // Cause and freeze checks
  a_cause_rec: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && lockup_reset && !(|src[rwd_pkg::SRC_SOFT:rwd_pkg::SRC_POR]))
    |=> reset_cause[rwd_pkg::SRC_LOCKUP])
    else $error("cause not recorded");

  a_cause_pow: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && power_on_reset
    |=> reset_cause[rwd_pkg::SRC_POR])
    else $error("power-on cause not recorded");

  a_freeze_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en
    |=> $stable(clock_resume_req) && $stable(wake_irq_pending) && $stable(reset_cause))
    else $error("state moved while clock enable low");
endmodule

// file: dv/rwd_irq_model.sv
// Interrupt controller model that takes pending wake interrupts
`timescale 1ns/1ps
module rwd_irq_model (
  input  wire logic clk,
  input  wire logic ack_en,
  input  wire logic wake_irq_pending,
  output logic      irq_ack
);
  initial irq_ack = 1'b0;
  // One take pulse per pending wake, driven off the sampling edge
  always @(negedge clk) irq_ack <= ack_en && wake_irq_pending && !irq_ack;
endmodule

// file: dv/rwd_top_tb.sv
// Self-checking bench for reset distribution and wake detection
`timescale 1ns/1ps
module rwd_top_tb;
  logic               clk, sys_rst, clk_en, clkgen_wake, clkgen_on_slow_internal_ref_clock, nmi_req, irq_ack, ack_en;
  logic               clock_resume_req, wake_irq_pending;
  logic [10:0]        src, reset_cause;
  logic [7:0]         pin_irq, pin_irq_en, peri_wake, module_rst;
  rwd_pkg::rwd_mode_t power_mode;
  int                 err_total, checks, cyc;
  rwd_top i_rwd_top (.clk, .sys_rst, .clk_en, .power_on_reset(src[0]), .low_voltage_reset(src[1]),
    .pin_reset(src[2]), .watchdog_reset(src[3]), .clock_loss_reset(src[4]), .lock_loss_reset(src[5]),
    .stop_ack_error_reset(src[6]), .software_reset(src[7]), .lockup_reset(src[8]),
    .debug_port_reset_request(src[9]), .debug_reset(src[10]), .power_mode, .pin_irq, .pin_irq_en,
    .peri_wake, .clkgen_wake, .clkgen_on_slow_internal_ref_clock, .nmi_req, .irq_ack, .module_rst, .clock_resume_req,
    .wake_irq_pending, .reset_cause);
  rwd_irq_model i_rwd_irq_model (.clk, .ack_en, .wake_irq_pending, .irq_ack);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(logic [10:0] got, logic [10:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Async assert, hold one edge, release at the second edge
  task automatic src_pulse(int i, logic [7:0] m);
    @(negedge clk);
    src[i] = 1'b1;
    #1 chk(module_rst, m);
    @(negedge clk);
    src[i] = 1'b0;
    @(posedge clk);
    #1 chk(module_rst, m);
    @(posedge clk);
    #1 chk(module_rst, 8'h00);
    chk(reset_cause, 11'h001 << i);
  endtask
  // Kinds: 0 nmi, 1 enabled pin, 2 masked pin, 3 peripheral, 4 clkgen on slow clock, 5 clkgen otherwise
  task automatic wake(rwd_pkg::rwd_mode_t md, int k, logic e);
    @(negedge clk);
    power_mode = md;
    ack_en = 1'b0;
    nmi_req = (k == 0);
    pin_irq = (k == 1 || k == 2) ? 8'h08 : 8'h00;
    pin_irq_en = (k == 1) ? 8'h08 : 8'h00;
    peri_wake = (k == 3) ? 8'h04 : 8'h00;
    clkgen_wake = (k >= 4);
    clkgen_on_slow_internal_ref_clock = (k == 4);
    repeat (3) @(posedge clk);
    #1 chk(clock_resume_req, e);
    chk(wake_irq_pending, e);
    @(negedge clk);
    {nmi_req, clkgen_wake, clkgen_on_slow_internal_ref_clock, pin_irq, peri_wake} = '0;
    power_mode = rwd_pkg::RWD_RUN;
    ack_en = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(clock_resume_req, 1'b0);
    chk(wake_irq_pending, 1'b0);
  endtask
  task automatic test_power();
    for (int i = 0; i < 2; i++) src_pulse(i, 8'hff);
  endtask
  task automatic test_system();
    power_mode = rwd_pkg::RWD_STOP;
    for (int i = 2; i < 11; i++) src_pulse(i, 8'hbf);
    chk(clock_resume_req, 1'b1);
  endtask
  task automatic test_deep_wake();
    wake(rwd_pkg::RWD_PSTOP, 0, 1'b1);
    wake(rwd_pkg::RWD_STOP, 0, 1'b1);
    wake(rwd_pkg::RWD_VERY_LOW_POWER_STOP, 0, 1'b1);
    wake(rwd_pkg::RWD_STOP, 1, 1'b1);
    wake(rwd_pkg::RWD_VERY_LOW_POWER_STOP, 2, 1'b0);
    wake(rwd_pkg::RWD_VERY_LOW_POWER_STOP, 3, 1'b1);
  endtask
  task automatic test_clkgen();
    wake(rwd_pkg::RWD_STOP, 4, 1'b1);
    wake(rwd_pkg::RWD_VERY_LOW_POWER_STOP, 4, 1'b0);
    wake(rwd_pkg::RWD_STOP, 5, 1'b0);
  endtask
  task automatic test_wait();
    wake(rwd_pkg::RWD_WAIT, 0, 1'b0);
    wake(rwd_pkg::RWD_VERY_LOW_POWER_WAIT, 1, 1'b0);
  endtask
  initial begin
    {sys_rst, clk_en, src, nmi_req, clkgen_wake, clkgen_on_slow_internal_ref_clock, ack_en} = {1'b1, 1'b1, 15'h0000};
    {pin_irq, pin_irq_en, peri_wake} = '0;
    power_mode = rwd_pkg::RWD_RUN;
    repeat (5) @(posedge clk);
    #1 chk(module_rst, 8'hff);
    @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(module_rst, 8'h00);
    chk(reset_cause, rwd_pkg::CAUSE_RST);
    test_power();
    test_system();
    test_deep_wake();
    test_clkgen();
    test_wait();
    complete_run();
  end
endmodule
